// ==== logic/uart_chan_regs.sv ====
// Function
// - Enhanced fields writable only when enhanced bit set
// - Gated fields read zero, written as zero otherwise
// - Flow-character flags clear after read, upper zero
// - Modem-control bits 2,3 are storage, no pins
// - Modem-control bits 2,3 loop back to status
// - Shared offsets: read and write reach different registers
`include "uart_chan_map.svh"

module uart_chan_regs #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic                   I_SYS_CLK,
  input  wire logic                   I_ARST_N,
  input  wire logic                   I_CS_N,
  input  wire logic                   I_RD_N,
  input  wire logic                   I_WR_N,
  input  wire logic [3:0]             I_ADDR,
  input  wire logic [7:0]             I_DATA,
  input  wire logic [3:0]             I_MODEM_N,
  input  wire uart_chan_pkg::status_t I_STATUS,
  output      logic [7:0]             O_DATA,
  output      logic                   O_DATA_OE,
  output      uart_chan_pkg::cfg_t    O_CFG,
  output      uart_chan_pkg::pulse_t  O_PULSE
);

  initial begin
    if (SYNC_STAGES < 2) $error("SYNC_STAGES must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; address and data travel with the strobes

  localparam int SW = 3 + 4 + 8 + 4;
  logic [SW-1:0] sync_q [SYNC_STAGES];
  logic [SW-1:0] pins_s;
  logic          cs_n_s;
  logic          rd_n_s;
  logic          wr_n_s;
  logic [3:0]    addr_s;
  logic [7:0]    wdata_s;
  logic [3:0]    modem_n_s;

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int i = 0; i < SYNC_STAGES; i++) sync_q[i] <= {SW{1'b1}};
    end else begin
      sync_q[0] <= {I_CS_N, I_RD_N, I_WR_N, I_ADDR, I_DATA, I_MODEM_N};
      for (int i = 1; i < SYNC_STAGES; i++) sync_q[i] <= sync_q[i-1];
    end
  end

  assign pins_s = sync_q[SYNC_STAGES-1];
  assign {cs_n_s, rd_n_s, wr_n_s, addr_s, wdata_s, modem_n_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Strobe edges: one action per bus cycle however long it lasts

  logic rd_act;
  logic wr_act;
  logic rd_act_q;
  logic wr_act_q;
  logic rd_stb;
  logic wr_stb;

  assign rd_act = !cs_n_s && !rd_n_s;
  assign wr_act = !cs_n_s && !wr_n_s;
  assign rd_stb = rd_act && !rd_act_q;
  assign wr_stb = wr_act && !wr_act_q;

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] div_low_q, div_high_q, ier_q, fcr_q, lcr_q, mcr_q, spr_q;
  logic [7:0] feature_control_q, efr_q, tx_trig_q, rx_trig_q, hd_delay_q;
  logic [7:0] stop1_q, stop2_q, resume1_q, resume2_q;
  logic [3:0] div_frac_q;
  logic       enh;
  logic       dlab;
  logic [7:0] ier_eff, fcr_eff, mcr_eff, hd_eff;

  assign enh  = efr_q[`EFR_ENH_BIT];
  assign dlab = lcr_q[`LCR_DIV_BIT];

  // Gating applies on read and on use, so stale enhanced bits never act
  function automatic logic [7:0] gate(input logic [7:0] v, input logic [7:0] m,
                                      input logic en);
    gate = en ? v : (v & ~m);
  endfunction

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  assign ier_eff = gate(ier_q, `IER_ENH_MASK, enh);
  assign fcr_eff = gate(fcr_q, `FCR_ENH_MASK, enh);
  assign mcr_eff = gate(mcr_q, `MCR_ENH_MASK, enh);
  assign hd_eff  = gate(hd_delay_q, `MSW_ENH_MASK, enh);

  logic [7:0] wd_ier, wd_fcr, wd_mcr, wd_msw;
  assign wd_ier = gate(wdata_s, `IER_ENH_MASK, enh);
  assign wd_fcr = gate(wdata_s, `FCR_ENH_MASK, enh);
  assign wd_mcr = gate(wdata_s, `MCR_ENH_MASK, enh);
  assign wd_msw = gate(wdata_s, `MSW_ENH_MASK, enh);

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      div_low_q  <= `RST_BYTE;
      div_high_q <= `RST_BYTE;
      div_frac_q <= `RST_NIB;
      ier_q      <= `RST_BYTE;
      fcr_q      <= `RST_BYTE;
      lcr_q      <= `RST_BYTE;
      mcr_q      <= `RST_BYTE;
      spr_q      <= `RST_BYTE;
      feature_control_q     <= `RST_BYTE;
      efr_q      <= `RST_BYTE;
      tx_trig_q  <= `RST_BYTE;
      rx_trig_q  <= `RST_BYTE;
      hd_delay_q <= `RST_BYTE;
      stop1_q    <= `RST_BYTE;
      stop2_q    <= `RST_BYTE;
      resume1_q  <= `RST_BYTE;
      resume2_q  <= `RST_BYTE;
    end else if (wr_stb) begin
      case (addr_s)
        `OFS_HOLD:    if (dlab) div_low_q <= wdata_s;
        `OFS_IER: begin
          if (dlab) div_high_q <= wdata_s;
          else ier_q <= wd_ier;
        end
        `OFS_ISR: begin
          if (dlab) div_frac_q <= wdata_s[3:0];
          else fcr_q <= wd_fcr;
        end
        `OFS_LCR:     lcr_q      <= wdata_s;
        `OFS_MCR:     mcr_q      <= wd_mcr;
        `OFS_MSR:     hd_delay_q <= wd_msw;
        `OFS_SPR:     spr_q      <= wdata_s;
        `OFS_FEATURE_CONTROL:    feature_control_q     <= wdata_s;
        `OFS_EFR:     efr_q      <= wdata_s;
        `OFS_TXLVL:   tx_trig_q  <= wdata_s;
        `OFS_RXLVL:   rx_trig_q  <= wdata_s;
        `OFS_FLOW:    stop1_q    <= wdata_s;
        `OFS_STOP2:   stop2_q    <= wdata_s;
        `OFS_RESUME1: resume1_q  <= wdata_s;
        `OFS_RESUME2: resume2_q  <= wdata_s;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flow-character flags, cleared by a read; a new event wins over the clear

  logic [3:0] flow_q;
  logic       flow_rd;
  assign flow_rd = rd_stb && hit(addr_s, `OFS_FLOW);

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) flow_q <= `RST_NIB;
    else flow_q <= (flow_rd ? `RST_NIB : flow_q) | I_STATUS.flow_evt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Modem status; loopback replaces the pins so no outside pin is needed

  logic       loop;
  logic [3:0] mdm_now;
  logic [3:0] mdm_q;
  logic [3:0] delta_q;
  logic       msr_rd;

  assign loop    = mcr_q[`MCR_LOOP_BIT];
  // Order is cd, ri, dsr, cts; bits 2 and 3 of modem control only act here
  assign mdm_now = loop ? {mcr_eff[3], mcr_eff[2], mcr_q[0], mcr_q[1]}
                        : ~modem_n_s;
  assign msr_rd  = rd_stb && hit(addr_s, `OFS_MSR);

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      mdm_q   <= `RST_NIB;
      delta_q <= `RST_NIB;
    end else begin
      mdm_q   <= mdm_now;
      delta_q <= (msr_rd ? `RST_NIB : delta_q) | (mdm_q ^ mdm_now);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer

  logic [7:0] rd_mux;
  logic [7:0] isr_val;

  assign isr_val = gate({fcr_q[0], fcr_q[0], I_STATUS.isr_low},
                        `ISR_ENH_MASK, enh);

  always_comb begin
    rd_mux = `RST_BYTE;
    case (addr_s)
      `OFS_HOLD:  rd_mux = dlab ? div_low_q : I_STATUS.rx_data;
      `OFS_IER:   rd_mux = dlab ? div_high_q : ier_eff;
      `OFS_ISR:   rd_mux = dlab ? ({4'h0, div_frac_q} & `FRAC_MASK)
                                : isr_val;
      `OFS_LCR:   rd_mux = lcr_q;
      `OFS_MCR:   rd_mux = mcr_eff;
      `OFS_LSR:   rd_mux = I_STATUS.line_status;
      `OFS_MSR:   rd_mux = {mdm_q, delta_q};
      `OFS_SPR:   rd_mux = spr_q;
      `OFS_FEATURE_CONTROL:  rd_mux = feature_control_q;
      `OFS_EFR:   rd_mux = efr_q;
      `OFS_TXLVL: rd_mux = I_STATUS.tx_level;
      `OFS_RXLVL: rd_mux = I_STATUS.rx_level;
      `OFS_FLOW:  rd_mux = {4'h0, flow_q};
      default:    rd_mux = `RST_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_DATA    <= `RST_BYTE;
      O_DATA_OE <= 1'b0;
    end else begin
      O_DATA_OE <= rd_act;
      if (rd_stb) O_DATA <= rd_mux;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_PULSE <= '0;
    end else begin
      O_PULSE.tx_wr   <= wr_stb && hit(addr_s, `OFS_HOLD) && !dlab;
      O_PULSE.tx_data <= wdata_s;
      O_PULSE.rx_rd   <= rd_stb && hit(addr_s, `OFS_HOLD) && !dlab;
      O_PULSE.isr_rd  <= rd_stb && hit(addr_s, `OFS_ISR) && !dlab;
      O_PULSE.lsr_rd  <= rd_stb && hit(addr_s, `OFS_LSR);
      O_PULSE.msr_rd  <= msr_rd;
      O_PULSE.fcr_wr  <= wr_stb && hit(addr_s, `OFS_ISR) && !dlab;
    end
  end

  // Bits 2 and 3 of modem control stay internal: masked from the core
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_CFG <= '0;
    end else begin
      O_CFG.div_low  <= div_low_q;
      O_CFG.div_high <= div_high_q;
      O_CFG.div_frac <= div_frac_q;
      O_CFG.interrupt_enable      <= ier_eff;
      O_CFG.fifo_control      <= fcr_eff;
      O_CFG.line_control      <= lcr_q;
      O_CFG.modem_control      <= {mcr_eff[7:4], 2'b00, mcr_eff[1:0]};
      O_CFG.feature_control     <= feature_control_q;
      O_CFG.enhanced_function      <= efr_q;
      O_CFG.tx_trig  <= tx_trig_q;
      O_CFG.rx_trig  <= rx_trig_q;
      O_CFG.stop1    <= stop1_q;
      O_CFG.stop2    <= stop2_q;
      O_CFG.resume1  <= resume1_q;
      O_CFG.resume2  <= resume2_q;
      O_CFG.hd_delay <= hd_eff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);

  AST_ENH_WRITE: assert property (
    wr_stb && hit(addr_s, `OFS_IER) && !dlab && enh
    |=> ier_q == $past(wdata_s))
    else $error("Enhanced interrupt-enable write not stored");

  AST_GATED_READ: assert property (
    rd_stb && hit(addr_s, `OFS_IER) && !dlab && !enh
    |=> O_DATA[7:5] == 3'h0)
    else $error("Gated interrupt-enable bits read nonzero");

  AST_GATED_OUT: assert property (
    !enh ##1 !enh |-> O_CFG.interrupt_enable[7:5] == 3'h0 && O_CFG.modem_control[7:5] == 3'h0)
    else $error("Gated bits reach the core while disabled");

  AST_FLOW_CLEAR: assert property (
    flow_rd && I_STATUS.flow_evt == 4'h0 |=> flow_q == 4'h0 ##1 O_DATA[7:4] == 4'h0)
    else $error("Flow flags not cleared by read");

  AST_OP_STORE: assert property (
    wr_stb && hit(addr_s, `OFS_MCR) && enh
    |=> mcr_q[3:2] == $past(wdata_s[3:2]) && O_CFG.modem_control[3:2] == 2'h0)
    else $error("Modem-control storage bits wrong");

  AST_LOOPBACK: assert property (
    loop |=> mdm_q[3:2] == $past(mcr_eff[3:2]))
    else $error("Loopback does not return storage bits");

  AST_MSW_GATED: assert property (
    wr_stb && hit(addr_s, `OFS_MSR) && !enh
    |=> hd_delay_q[7:2] == 6'h00)
    else $error("Gated delay bits stored while disabled");

  AST_TXLVL_READ: assert property (
    rd_stb && hit(addr_s, `OFS_TXLVL)
    |=> O_DATA == $past(I_STATUS.tx_level))
    else $error("Level read did not return the core level");

  AST_DIV_READ: assert property (
    rd_stb && hit(addr_s, `OFS_HOLD) && dlab
    |=> O_DATA == $past(div_low_q))
    else $error("Divisor bank read returned wrong register");

  AST_SHARED_WRITE: assert property (
    wr_stb && hit(addr_s, `OFS_HOLD) && !dlab
    |=> O_PULSE.tx_wr && $stable(div_low_q))
    else $error("Holding write went to wrong register");

  AST_DIV_BANK: assert property (
    wr_stb && hit(addr_s, `OFS_HOLD) && dlab
    |=> div_low_q == $past(wdata_s) && !O_PULSE.tx_wr)
    else $error("Divisor bank write failed");

  COV_FLOW_READ:  cover property (flow_rd && flow_q != 4'h0);
  COV_DIV_WRITE:  cover property (wr_stb && dlab && hit(addr_s, `OFS_ISR));
  COV_LOOP_DELTA: cover property (loop && (mdm_q != mdm_now));
  COV_ENH_WRITE:  cover property (wr_stb && enh && hit(addr_s, `OFS_MCR));

endmodule // uart_chan_regs

// ==== logic/uart_chan_map.svh ====
`ifndef UART_CHAN_MAP_SVH
`define UART_CHAN_MAP_SVH
// Register offsets on the 4-bit channel address
`define OFS_HOLD     4'h0
`define OFS_IER      4'h1
`define OFS_ISR      4'h2
`define OFS_LCR      4'h3
`define OFS_MCR      4'h4
`define OFS_LSR      4'h5
`define OFS_MSR      4'h6
`define OFS_SPR      4'h7
`define OFS_FEATURE_CONTROL     4'h8
`define OFS_EFR      4'h9
`define OFS_TXLVL    4'hA
`define OFS_RXLVL    4'hB
`define OFS_FLOW     4'hC
`define OFS_STOP2    4'hD
`define OFS_RESUME1  4'hE
`define OFS_RESUME2  4'hF
// Field positions
`define LCR_DIV_BIT  7
`define EFR_ENH_BIT  4
`define MCR_LOOP_BIT 4
// Enhanced-gated field masks, then the divisor-fraction read mask
`define IER_ENH_MASK 8'hE0
`define ISR_ENH_MASK 8'h30
`define FCR_ENH_MASK 8'h30
`define MCR_ENH_MASK 8'hEC
`define MSW_ENH_MASK 8'hFC
`define FRAC_MASK    8'h0F
// Reset values
`define RST_BYTE     8'h00
`define RST_NIB      4'h0
`endif

// ==== logic/uart_chan_pkg.sv ====
package uart_chan_pkg;
  typedef struct packed {
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [3:0] div_frac;
    logic [7:0] interrupt_enable;
    logic [7:0] fifo_control;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] feature_control;
    logic [7:0] enhanced_function;
    logic [7:0] tx_trig;
    logic [7:0] rx_trig;
    logic [7:0] stop1;
    logic [7:0] stop2;
    logic [7:0] resume1;
    logic [7:0] resume2;
    logic [7:0] hd_delay;
  } cfg_t;

  typedef struct packed {
    logic [7:0] rx_data;
    logic [5:0] isr_low;
    logic [7:0] line_status;
    logic [7:0] tx_level;
    logic [7:0] rx_level;
    logic [3:0] flow_evt;
  } status_t;

  typedef struct packed {
    logic       tx_wr;
    logic [7:0] tx_data;
    logic       rx_rd;
    logic       isr_rd;
    logic       lsr_rd;
    logic       msr_rd;
    logic       fcr_wr;
  } pulse_t;
endpackage

// ==== sim/uart_chan_host.sv ====
////////////////////////////////////////////////////////////////////////////////
// Host processor model on the parallel register bus
module uart_chan_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output      logic       o_cs_n,
  output      logic       o_rd_n,
  output      logic       o_wr_n,
  output      logic [3:0] o_addr,
  output      logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_cs_n  = 1'b1;
    o_rd_n  = 1'b1;
    o_wr_n  = 1'b1;
    o_addr  = 4'h0;
    o_wdata = 8'h00;
  end

  // Strobe held 5 cycles against a 3-cycle synchronised answer, idle 4 after
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr  = a;
    o_wdata = d;
    o_cs_n  = 1'b0;
    o_wr_n  = 1'b0;
    repeat (5) @(negedge i_clk);
    o_wr_n  = 1'b1;
    o_cs_n  = 1'b1;
    // Released data lines do not keep the old value
    o_wdata = ~d;
    repeat (4) @(negedge i_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_cs_n = 1'b0;
    o_rd_n = 1'b0;
    repeat (5) @(negedge i_clk);
    d      = i_rdata;
    o_rd_n = 1'b1;
    o_cs_n = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask
endmodule // uart_chan_host

// ==== sim/uart_chan_regs_test.sv ====
////////////////////////////////////////////////////////////////////////////////
module uart_chan_regs_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clk;
  logic                   arst_n;
  logic                   cs_n;
  logic                   rd_n;
  logic                   wr_n;
  logic [3:0]             addr;
  logic [7:0]             wdata;
  logic [3:0]             modem_n;
  uart_chan_pkg::status_t status;
  logic [7:0]             rdata;
  logic                   oe;
  uart_chan_pkg::cfg_t    cfg;
  uart_chan_pkg::pulse_t  pulse;
  logic [7:0]             r;
  logic [7:0]             tx_seen;
  logic                   oe_seen;
  int                     n_fail;
  int                     comparisons;
  int                     cycles;

  uart_chan_regs dut_u (
    .I_SYS_CLK (clk),
    .I_ARST_N  (arst_n),
    .I_CS_N    (cs_n),
    .I_RD_N    (rd_n),
    .I_WR_N    (wr_n),
    .I_ADDR    (addr),
    .I_DATA    (wdata),
    .I_MODEM_N (modem_n),
    .I_STATUS  (status),
    .O_DATA    (rdata),
    .O_DATA_OE (oe),
    .O_CFG     (cfg),
    .O_PULSE   (pulse)
  );

  uart_chan_host host_u (
    .i_clk   (clk),
    .i_rdata (rdata),
    .o_cs_n  (cs_n),
    .o_rd_n  (rd_n),
    .o_wr_n  (wr_n),
    .o_addr  (addr),
    .o_wdata (wdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Transmit pulse lasts one cycle, so it is caught here rather than polled
  always @(posedge clk) begin
    if (pulse.tx_wr === 1'b1) begin
      tx_seen <= pulse.tx_data;
    end
    if (oe === 1'b1) begin
      oe_seen <= 1'b1;
    end
  end

  // Whole run needs about 500 cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check(cfg.interrupt_enable, 8'h00);
    check(cfg.line_control, 8'h00);
    check(cfg.modem_control, 8'h00);
    check(cfg.enhanced_function, 8'h00);
    check({7'h00, oe}, 8'h00);
  endtask

  task automatic test_gating();
    status.isr_low = 6'h3F;
    host_u.wr(4'h1, 8'hE5);
    host_u.rd(4'h1, r);
    check(r, 8'h05);
    check(cfg.interrupt_enable, 8'h05);
    host_u.wr(4'h9, 8'h10);
    host_u.wr(4'h1, 8'hE5);
    host_u.rd(4'h1, r);
    check(r, 8'hE5);
    check(cfg.interrupt_enable, 8'hE5);
    host_u.wr(4'h4, 8'hEF);
    host_u.rd(4'h4, r);
    check(r, 8'hEF);
    check(cfg.modem_control, 8'hE3);
    host_u.rd(4'h2, r);
    check(r, 8'h3F);
    // Clearing the enable hides what was stored before
    host_u.wr(4'h9, 8'h00);
    host_u.rd(4'h1, r);
    check(r, 8'h05);
    host_u.rd(4'h2, r);
    check(r, 8'h0F);
    host_u.wr(4'h4, 8'hEF);
    host_u.rd(4'h4, r);
    check(r, 8'h03);
    check({7'h00, oe_seen}, 8'h01);
  endtask

  task automatic test_tail();
    host_u.wr(4'h6, 8'hFF);
    check(cfg.hd_delay, 8'hFF);
    host_u.wr(4'h2, 8'hF1);
    check(cfg.fifo_control, 8'hF1);
    host_u.rd(4'h2, r);
    check(r, 8'hFF);
    host_u.wr(4'hC, 8'hAA);
    host_u.wr(4'hD, 8'hBB);
    host_u.wr(4'hE, 8'hCC);
    host_u.wr(4'hF, 8'hDD);
    check(cfg.stop1, 8'hAA);
    check(cfg.stop2, 8'hBB);
    check(cfg.resume1, 8'hCC);
    check(cfg.resume2, 8'hDD);
    host_u.wr(4'h9, 8'h00);
    check(cfg.hd_delay, 8'h03);
    check(cfg.fifo_control, 8'hC1);
    host_u.rd(4'h2, r);
    check(r, 8'hCF);
  endtask

  task automatic test_divisor();
    host_u.wr(4'h3, 8'h80);
    host_u.wr(4'h0, 8'h12);
    host_u.wr(4'h1, 8'h34);
    host_u.wr(4'h2, 8'hAB);
    host_u.rd(4'h0, r);
    check(r, 8'h12);
    host_u.rd(4'h1, r);
    check(r, 8'h34);
    host_u.rd(4'h2, r);
    check(r, 8'h0B);
    check({4'h0, cfg.div_frac}, 8'h0B);
    host_u.wr(4'h3, 8'h03);
    status.rx_data = 8'hC3;
    host_u.rd(4'h0, r);
    check(r, 8'hC3);
    host_u.wr(4'h0, 8'h5A);
    check(tx_seen, 8'h5A);
    host_u.rd(4'h1, r);
    check(r, 8'h05);
    check(cfg.div_high, 8'h34);
  endtask

  task automatic test_shared();
    status.tx_level = 8'h11;
    status.rx_level = 8'h22;
    host_u.wr(4'hA, 8'h77);
    host_u.wr(4'hB, 8'h66);
    host_u.rd(4'hA, r);
    check(r, 8'h11);
    host_u.rd(4'hB, r);
    check(r, 8'h22);
    check(cfg.tx_trig, 8'h77);
    check(cfg.rx_trig, 8'h66);
    host_u.wr(4'h7, 8'h96);
    host_u.rd(4'h7, r);
    check(r, 8'h96);
  endtask

  task automatic test_flow();
    @(negedge clk);
    status.flow_evt = 4'h5;
    @(negedge clk);
    status.flow_evt = 4'h0;
    host_u.rd(4'hC, r);
    check(r, 8'h05);
    host_u.rd(4'hC, r);
    check(r, 8'h00);
  endtask

  task automatic test_loop();
    modem_n = 4'h6;
    repeat (6) @(negedge clk);
    host_u.rd(4'h6, r);
    check(r & 8'hF0, 8'h90);
    modem_n = 4'hF;
    host_u.wr(4'h4, 8'h1C);
    host_u.rd(4'h6, r);
    check(r & 8'hF0, 8'h00);
    host_u.wr(4'h9, 8'h10);
    host_u.wr(4'h4, 8'h1C);
    host_u.rd(4'h6, r);
    check(r & 8'hF0, 8'hC0);
    check(cfg.modem_control, 8'h10);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n      = 1'b0;
    modem_n     = 4'hF;
    status      = '0;
    tx_seen     = 8'h00;
    oe_seen     = 1'b0;
    n_fail      = 0;
    comparisons = 0;
    cycles      = 0;
    repeat (8) @(negedge clk);
    test_reset();
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    test_gating();
    test_divisor();
    test_shared();
    test_flow();
    test_loop();
    test_tail();
    print_verdict();
  end
endmodule // uart_chan_regs_test
